// ===== bscc_pkg.sv
/*
  Shared constants and types for the bridge-sensor calibration block:
  register map, word layouts, reset values and timing counts.
  Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
*/
package bscc_pkg;

  // Calibration memory geometry
  localparam int unsigned CAL_WORDS      = 64;
  localparam int unsigned CAL_DATA_W     = 4;
  localparam int unsigned CAL_ADDR_W     = 6;

  // Calibration word indices (byte address is four times the index)
  localparam logic [5:0] IDX_T1_GAIN_LO   = 6'h00; // Words 0..2, low first
  localparam logic [5:0] IDX_OSC_TRIM     = 6'h03;
  localparam logic [5:0] IDX_COEF2_LO     = 6'h04; // Words 4..6
  localparam logic [5:0] IDX_SWAP_GAIN    = 6'h07;
  localparam logic [5:0] IDX_COEF1_LO     = 6'h08; // Words 8..10
  localparam logic [5:0] IDX_COEF0_LO     = 6'h0c; // Words 12..14
  localparam logic [5:0] IDX_T1_OFFS_LO   = 6'h10; // Words 16..18
  localparam logic [5:0] IDX_TSRC_OFFS    = 6'h17;
  localparam logic [5:0] IDX_TOFFS_UPPER  = 6'h1b;
  localparam logic [5:0] IDX_TAMP_TRIM    = 6'h1f;

  // Field positions inside the calibration words
  localparam int unsigned POS_INPUT_SWAP  = 0;
  localparam int unsigned POS_GAIN_STAGE1 = 1;
  localparam int unsigned POS_GAIN_STAGE2 = 2;
  localparam int unsigned POS_GAIN_STAGE3 = 3;
  localparam int unsigned POS_TEMP_SRC    = 0;

  // Extra block registers above the calibration words
  localparam logic [11:0] ADDR_STATUS     = 12'h100;
  localparam logic [11:0] ADDR_CHOP_DIV   = 12'h104;
  localparam int unsigned POS_ST_FAULT    = 16;
  localparam int unsigned POS_ST_PERR     = 17;

  // Reset values: erased word carries a valid odd parity
  localparam logic [4:0]  CAL_WORD_RESET  = 5'h10;
  localparam logic [15:0] CHOP_DIV_RESET  = 16'h0008;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Polynomial precision
  localparam int unsigned ALU_W           = 12;
  localparam int unsigned FINE_W          = 10;

  // One stored calibration word
  typedef struct packed {
    logic                  parity;
    logic [CAL_DATA_W-1:0] data;
  } bscc_cal_word_t;

  // Decoded configuration codes
  typedef struct packed {
    logic [3:0] osc_trim;
    logic       temp_src;
    logic [2:0] amp_gain;
    logic [4:0] amp_offs;
    logic       swap;
    logic [2:0] coarse;
  } bscc_cfg_t;

endpackage

// ===== bscc_core.sv
/*
  Calibration memory, configuration decode and fine-span polynomial of a
  bridge-sensor conditioning device, with an AXI4-Lite register slave.
  Assumes temperature readings arrive synchronous to aclk with a valid
  strobe, and that the analog chain consumes the registered codes.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
module bscc_core
  import bscc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [9:0]        temp_reading,
  input  wire logic              temp_valid,
  output bscc_cfg_t              cfg_codes,
  output logic                   chop_ctrl,
  output logic [FINE_W-1:0]      fine_span_factor,
  output logic                   fault_band
);

  // Calibration memory and block state
  bscc_cal_word_t mem_q [CAL_WORDS];
  bscc_cal_word_t mem_d [CAL_WORDS];
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic        arready_q, arready_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        perr_q, perr_d;
  logic [15:0] chop_div_q, chop_div_d, chop_cnt_q, chop_cnt_d;
  logic        chop_phase_q, chop_phase_d, chop_out_q, chop_out_d;
  logic [10:0] temp_q, temp_d;
  logic [FINE_W-1:0] fine_q, fine_d;
  logic        fault_q, fault_d;
  bscc_cfg_t   cfg_q, cfg_d;

  logic        do_write, bad_parity, wr_map, rd_map;
  logic [5:0]  wr_idx, rd_idx;

  // Write completes once both address and data are held
  assign do_write   = aw_full_q && w_full_q && !bvalid_q;
  assign wr_idx     = awaddr_q[7:2];
  assign rd_idx     = s_axi_araddr[7:2];
  assign wr_map     = (awaddr_q[11:8] == 4'h0) || (awaddr_q == ADDR_STATUS)
                      || (awaddr_q == ADDR_CHOP_DIV);
  assign rd_map     = (s_axi_araddr[11:8] == 4'h0)
                      || (s_axi_araddr == ADDR_STATUS)
                      || (s_axi_araddr == ADDR_CHOP_DIV);
  // Odd parity holds when the XOR of all five bits is one
  assign bad_parity = ~^wdata_q[4:0];

  // AXI write channels, taken in either order
  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && !aw_full_q)
    begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q)
    begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
  end

  // Memory, parity flag and divider setting updated by writes
  always_comb
  begin
    mem_d      = mem_q;
    perr_d     = perr_q;
    chop_div_d = chop_div_q;
    if (do_write && wstrb0_q)
    begin
      if (awaddr_q[11:8] == 4'h0)
      begin
        // Word stored as written; a wrong parity is flagged, not refused
        mem_d[wr_idx] = bscc_cal_word_t'(wdata_q[4:0]);
      end
      else if (awaddr_q == ADDR_STATUS && wdata_q[POS_ST_PERR])
        perr_d = 1'b0;
      else if (awaddr_q == ADDR_CHOP_DIV)
        chop_div_d = wdata_q[15:0];
    end
    // A parity error in the same write beats the clear
    if (do_write && wstrb0_q && awaddr_q[11:8] == 4'h0 && bad_parity)
      perr_d = 1'b1;
  end

  // AXI read channel: one read at a time, data held until rready
  always_comb
  begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid && arready_q)
    begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = rd_map ? RESP_OKAY : RESP_SLVERR;
      rdata_d   = 32'h0000_0000;
      if (s_axi_araddr[11:8] == 4'h0)
        rdata_d[4:0] = mem_q[rd_idx];
      else if (s_axi_araddr == ADDR_STATUS)
      begin
        rdata_d[FINE_W-1:0]   = fine_q;
        rdata_d[POS_ST_FAULT] = fault_q;
        rdata_d[POS_ST_PERR]  = perr_q;
      end
      else if (s_axi_araddr == ADDR_CHOP_DIV)
        rdata_d[15:0] = chop_div_q;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  // Configuration decode from the memory words
  always_comb
  begin
    cfg_d          = cfg_q;
    cfg_d.osc_trim = mem_q[IDX_OSC_TRIM].data;
    cfg_d.temp_src = mem_q[IDX_TSRC_OFFS].data[POS_TEMP_SRC];
    cfg_d.amp_gain = mem_q[IDX_TAMP_TRIM].data[2:0];
    // Offset low three bits share word 23 with the source select
    cfg_d.amp_offs = {mem_q[IDX_TOFFS_UPPER].data[1:0],
                      mem_q[IDX_TSRC_OFFS].data[3:1]};
    cfg_d.swap     = mem_q[IDX_SWAP_GAIN].data[POS_INPUT_SWAP];
    // Bit order stage3..stage1; zero is the lower gain of each stage
    cfg_d.coarse   = {mem_q[IDX_SWAP_GAIN].data[POS_GAIN_STAGE3],
                      mem_q[IDX_SWAP_GAIN].data[POS_GAIN_STAGE2],
                      mem_q[IDX_SWAP_GAIN].data[POS_GAIN_STAGE1]};
  end

  // Chopping divider; the swap inverts the phase, a half-period shift
  always_comb
  begin
    chop_cnt_d   = chop_cnt_q + 16'h0001;
    chop_phase_d = chop_phase_q;
    if (chop_cnt_q + 16'h0001 >= chop_div_q)
    begin
      chop_cnt_d   = 16'h0000;
      chop_phase_d = !chop_phase_q;
    end
    chop_out_d = chop_phase_q ^ cfg_q.swap;
  end

  // Fine-span polynomial in units of 2^-12
  logic        [11:0] t1_span;
  logic signed [11:0] coef1, coef2, delta_t;
  logic        [9:0]  coef0;
  logic signed [23:0] prod1, dt_sq;
  logic signed [24:0] prod2;
  logic signed [12:0] dt_sq_s;
  logic signed [17:0] term0, term1, term2, poly_sum;

  // The span copy of the room reference; the offset copy sits at 16..18
  assign t1_span  = {mem_q[IDX_T1_GAIN_LO + 6'h02].data,
                     mem_q[IDX_T1_GAIN_LO + 6'h01].data,
                     mem_q[IDX_T1_GAIN_LO].data};
  assign coef1    = {mem_q[IDX_COEF1_LO + 6'h02].data,
                     mem_q[IDX_COEF1_LO + 6'h01].data,
                     mem_q[IDX_COEF1_LO].data};
  assign coef2    = {mem_q[IDX_COEF2_LO + 6'h02].data,
                     mem_q[IDX_COEF2_LO + 6'h01].data,
                     mem_q[IDX_COEF2_LO].data};
  // Only the ten low bits of the zero-order coefficient are used
  assign coef0    = {mem_q[IDX_COEF0_LO + 6'h02].data[1:0],
                     mem_q[IDX_COEF0_LO + 6'h01].data,
                     mem_q[IDX_COEF0_LO].data};
  assign delta_t  = $signed({1'b0, temp_q}) - $signed(t1_span);
  assign prod1    = coef1 * delta_t;
  assign dt_sq    = delta_t * delta_t;
  assign dt_sq_s  = $signed({1'b0, dt_sq[22:11]});
  assign prod2    = coef2 * dt_sq_s;
  assign term0    = $signed({6'h00, coef0, 2'b00});
  assign term1    = 18'(prod1 >>> 9);
  assign term2    = 18'(prod2 >>> 9);
  assign poly_sum = term0 + term1 + term2;

  // Latch readings and register the truncated result in each cycle without a fault
  always_comb
  begin
    temp_d  = temp_valid ? {temp_reading, 1'b0} : temp_q;
    // Out of range shows as negative or a carry above the fraction
    fault_d = poly_sum[17] || (poly_sum[16:12] != 5'h00);
    // Last good code is kept while the fault band is driven
    fine_d  = fault_d ? fine_q : poly_sum[11:2];
  end

  // State registers, synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < CAL_WORDS; i++)
        mem_q[i] <= bscc_cal_word_t'(CAL_WORD_RESET);
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb0_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      arready_q    <= 1'b1;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h0000_0000;
      rresp_q      <= RESP_OKAY;
      perr_q       <= 1'b0;
      chop_div_q   <= CHOP_DIV_RESET;
      chop_cnt_q   <= 16'h0000;
      chop_phase_q <= 1'b0;
      chop_out_q   <= 1'b0;
      temp_q       <= 11'h000;
      fine_q       <= 10'h000;
      fault_q      <= 1'b0;
      cfg_q        <= '0;
    end
    else
    begin
      mem_q        <= mem_d;
      aw_full_q    <= aw_full_d;
      w_full_q     <= w_full_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb0_q     <= wstrb0_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      arready_q    <= arready_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
      perr_q       <= perr_d;
      chop_div_q   <= chop_div_d;
      chop_cnt_q   <= chop_cnt_d;
      chop_phase_q <= chop_phase_d;
      chop_out_q   <= chop_out_d;
      temp_q       <= temp_d;
      fine_q       <= fine_d;
      fault_q      <= fault_d;
      cfg_q        <= cfg_d;
    end
  end

  // Ports come straight from flip-flops; ready is the inverse of held
  assign s_axi_awready    = !aw_full_q;
  assign s_axi_wready     = !w_full_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign cfg_codes        = cfg_q;
  assign chop_ctrl        = chop_out_q;
  assign fine_span_factor = fine_q;
  assign fault_band       = fault_q;

  // Checks on the block's own state and outputs
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_mem_write;
    do_write && wstrb0_q && awaddr_q[11:8] == 4'h0
      |=> mem_q[$past(wr_idx)] == $past(wdata_q[4:0]);
  endproperty
  a_mem_write: assert property (p_mem_write)
    else $error("Calibration word not stored");

  property p_parity_flag;
    do_write && wstrb0_q && awaddr_q[11:8] == 4'h0 && bad_parity |=> perr_q;
  endproperty
  a_parity_flag: assert property (p_parity_flag)
    else $error("Even-parity word not flagged");

  property p_osc_trim;
    ##1 cfg_codes.osc_trim == $past(mem_q[IDX_OSC_TRIM].data);
  endproperty
  a_osc_trim: assert property (p_osc_trim)
    else $error("Oscillator trim not taken from word 3");

  property p_temp_src;
    ##1 cfg_codes.temp_src == $past(mem_q[IDX_TSRC_OFFS].data[0]);
  endproperty
  a_temp_src: assert property (p_temp_src)
    else $error("Temperature source select mismatch");

  property p_amp_offs;
    ##1 cfg_codes.amp_offs[4:3] == $past(mem_q[IDX_TOFFS_UPPER].data[1:0]);
  endproperty
  a_amp_offs: assert property (p_amp_offs)
    else $error("Amplifier offset upper bits mismatch");

  property p_chop_swap;
    $stable(cfg_q.swap)
      |=> chop_ctrl == ($past(chop_phase_q) ^ $past(cfg_q.swap));
  endproperty
  a_chop_swap: assert property (p_chop_swap)
    else $error("Chop phase not inverted by swap");

  property p_fine_trunc;
    !fault_d |=> fine_span_factor == $past(poly_sum[11:2]);
  endproperty
  a_fine_trunc: assert property (p_fine_trunc)
    else $error("Fine code not truncated polynomial");

  property p_fault;
    poly_sum < 0 |=> fault_band && $stable(fine_span_factor);
  endproperty
  a_fault: assert property (p_fault)
    else $error("Negative fraction did not raise fault band");

endmodule // bscc_core

// ===== bscc_programmer.sv
/*
  Model of the external calibration programmer: an AXI4-Lite master that
  writes and reads calibration words. Assumes the bench calls its tasks
  one at a time and that aclk is the slave's clock.
*/
module bscc_programmer
  import bscc_pkg::*;
(
  input  wire logic        aclk,
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // One write; each channel held until its own ready is sampled high
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // One read; rready stays high until rvalid is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Word write with odd parity; the oscillator trim is left alone
  task automatic put(input logic [5:0] i, input logic [3:0] n);
    logic [1:0] r;
    if (i == IDX_OSC_TRIM)
      return;
    wr(12'({i, 2'b00}), 32'({~^n, n}), 4'h1, r);
  endtask

  // Factory step only: sets the trim that put refuses to touch
  task automatic factory_trim(input logic [3:0] n);
    logic [1:0] r;
    wr(12'({IDX_OSC_TRIM, 2'b00}), 32'({~^n, n}), 4'h1, r);
  endtask

  // Twelve-bit two's complement value, low nibble first
  task automatic set12(input logic [5:0] b, input logic [11:0] v);
    put(b, v[3:0]);
    put(b + 6'h01, v[7:4]);
    put(b + 6'h02, v[11:8]);
  endtask

  // Room reference goes to both the span and the offset copies
  task automatic set_t1(input logic [11:0] v);
    set12(IDX_T1_GAIN_LO, v);
    set12(IDX_T1_OFFS_LO, v);
  endtask
endmodule // bscc_programmer

// ===== bridge_sensor_calib_config_bench.sv
/*
  Self-checking bench for the calibration block: register access, word
  decode, chopping period and fine-span polynomial. Assumes the
  programmer model drives the AXI4-Lite slave port.
*/
module bridge_sensor_calib_config_bench
  import bscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, temp_valid, chop_ctrl, fault_band;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [9:0] temp_reading, fine_span_factor;
  bscc_cfg_t cfg_codes;
  int n_fail, n_compared, n;
  int cyc = 0;

  bscc_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .temp_reading(temp_reading), .temp_valid(temp_valid),
    .cfg_codes(cfg_codes), .chop_ctrl(chop_ctrl),
    .fine_span_factor(fine_span_factor), .fault_band(fault_band));

  bscc_programmer u_prog (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests take
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: response %h expected %h", $time, g, e);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    u_prog.rd(a, d, r);
    chk(d, e);
    chk_rsp(r, er);
  endtask

  // Let the registered decode catch up with the last write
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // Cycles between two changes of the chopping control
  task automatic half(output int k);
    logic p;
    settle();
    p = chop_ctrl;
    k = 0;
    while (chop_ctrl === p && k < 100)
    begin
      @(posedge aclk);
      #1;
      k++;
    end
    p = chop_ctrl;
    k = 0;
    do
    begin
      @(posedge aclk);
      #1;
      k++;
    end while (chop_ctrl === p && k < 100);
  endtask

  // Sum in units of 2^-12: zero, first and second order terms
  function automatic longint psum(input logic [11:0] g0, g1, g2, t1,
                                  input logic [9:0] rd);
    longint dt;
    longint q;
    dt = longint'({rd, 1'b0}) - longint'(t1);
    q = (dt * dt) >>> 11;
    return longint'(g0[9:0]) * 4 + ((longint'($signed(g1)) * dt) >>> 9)
      + ((longint'($signed(g2)) * q) >>> 9);
  endfunction

  // Load coefficients, pulse a reading, compare code and fault flag
  task automatic poly(input logic [11:0] g0, g1, g2, t1,
                      input logic [9:0] rd);
    longint s;
    u_prog.set12(IDX_COEF0_LO, g0);
    u_prog.set12(IDX_COEF1_LO, g1);
    u_prog.set12(IDX_COEF2_LO, g2);
    u_prog.set_t1(t1);
    s = psum(g0, g1, g2, t1, rd);
    @(posedge aclk);
    temp_reading <= rd;
    temp_valid   <= 1'b1;
    @(posedge aclk);
    temp_valid <= 1'b0;
    settle();
    chk(32'(fault_band), 32'(s < 0 || s >= 4096));
    if (s >= 0 && s < 4096)
      chk(32'(fine_span_factor), 32'(s[11:2]));
  endtask

  // Main sequence
  initial
  begin
    {aresetn, temp_valid, temp_reading, n_fail, n_compared} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk(32'(cfg_codes), 32'h0000_0000);
    rdc(12'h000, 32'h0000_0010, RESP_OKAY);
    rdc(12'h0fc, 32'h0000_0010, RESP_OKAY);
    rdc(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    // Unmapped place and masked write
    u_prog.wr(12'h108, 32'h0000_0005, 4'h1, r);
    chk_rsp(r, RESP_SLVERR);
    rdc(12'h108, 32'h0000_0000, RESP_SLVERR);
    u_prog.wr(12'h004, 32'h0000_0001, 4'h0, r);
    chk_rsp(r, RESP_OKAY);
    rdc(12'h004, 32'h0000_0010, RESP_OKAY);
    // Even parity word is kept but flagged until cleared
    u_prog.wr(12'h004, 32'h0000_0000, 4'h1, r);
    rdc(12'h004, 32'h0000_0000, RESP_OKAY);
    u_prog.rd(ADDR_STATUS, d, r);
    chk(32'(d[POS_ST_PERR]), 32'h0000_0001);
    u_prog.wr(ADDR_STATUS, 32'h0002_0000, 4'hf, r);
    u_prog.rd(ADDR_STATUS, d, r);
    chk(32'(d[POS_ST_PERR]), 32'h0000_0000);
    // Word decode
    u_prog.factory_trim(4'hf);
    settle();
    chk(32'(cfg_codes.osc_trim), 32'h0000_000f);
    u_prog.factory_trim(4'h0);
    u_prog.put(IDX_SWAP_GAIN, 4'b1011);
    u_prog.put(IDX_TSRC_OFFS, 4'b1101);
    u_prog.put(IDX_TOFFS_UPPER, 4'b0010);
    u_prog.put(IDX_TAMP_TRIM, 4'b0101);
    settle();
    chk(32'(cfg_codes.osc_trim), 32'h0000_0000);
    chk(32'(cfg_codes.swap), 32'h0000_0001);
    chk(32'(cfg_codes.coarse), 32'h0000_0005);
    chk(32'(cfg_codes.temp_src), 32'h0000_0001);
    chk(32'(cfg_codes.amp_offs), 32'h0000_0016);
    chk(32'(cfg_codes.amp_gain), 32'h0000_0005);
    rdc(12'h05c, 32'h0000_000d, RESP_OKAY);
    // Half period with the swap set, then cleared
    u_prog.wr(ADDR_CHOP_DIV, 32'h0000_0004, 4'hf, r);
    half(n);
    chk(32'(n), 32'h0000_0004);
    u_prog.put(IDX_SWAP_GAIN, 4'b0110);
    u_prog.put(IDX_TSRC_OFFS, 4'b0000);
    settle();
    chk(32'(cfg_codes.swap), 32'h0000_0000);
    chk(32'(cfg_codes.coarse), 32'h0000_0003);
    chk(32'(cfg_codes.temp_src), 32'h0000_0000);
    half(n);
    chk(32'(n), 32'h0000_0004);
    // Polynomial: plain, each order, negative slope, both faults, top
    poly(12'h200, 12'h000, 12'h000, 12'h000, 10'h000);
    poly(12'h200, 12'h200, 12'h000, 12'h000, 10'h100);
    poly(12'h200, 12'h000, 12'h200, 12'h000, 10'h100);
    poly(12'h100, 12'he00, 12'h000, 12'h100, 10'h180);
    rdc(12'h048, 32'h0000_0001, RESP_OKAY);
    rdc(12'h008, 32'h0000_0001, RESP_OKAY);
    poly(12'h000, 12'he00, 12'h000, 12'h000, 10'h100);
    poly(12'h3ff, 12'h7ff, 12'h000, 12'h000, 10'h3ff);
    poly(12'h3ff, 12'h000, 12'h000, 12'h000, 10'h000);
    rdc(12'h040, 32'h0000_0010, RESP_OKAY);
    give_verdict();
  end
endmodule // bridge_sensor_calib_config_bench
